// ==== design/nvm_array.sv ====
/*
  flash data array: 64 bytes as eight rows, byte program and row erase.
  assumes one command at a time from the control block.
*/
`timescale 1ns/100ps
`include "nvm_cfg.svh"
module nvm_array #(
  parameter int ROWS = 8,
  parameter int ROW_BYTES = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic prog,
  input wire logic erase,
  output logic [7:0] rdata
);
  logic [7:0] mem [ROWS*ROW_BYTES];
  logic [7:0] next_mem [ROWS*ROW_BYTES];

  assign rdata = mem[addr];

  always_comb begin
    for (int i = 0; i < ROWS*ROW_BYTES; i++) begin
      next_mem[i] = mem[i];
      if (erase && (i / ROW_BYTES) == int'(addr[5:`NVM_ROW_LSB])) begin
        next_mem[i] = `NVM_ERASED_BYTE;
      end
    end
    if (prog) begin
      next_mem[addr] = wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < ROWS*ROW_BYTES; i++) begin
        mem[i] <= `NVM_ERASED_BYTE;
      end
    end else begin
      mem <= next_mem;
    end
  end
endmodule

// ==== design/nvm_cfg.svh ====
/*
  constants for the flash data memory control block: register offsets,
  field positions, reset values and cycle counts.
  assumes inclusion by bare name from design files.
*/
`ifndef NVM_CFG_SVH
`define NVM_CFG_SVH

`define NVM_ADDR_CONTROL 32'h0000_0000
`define NVM_ADDR_DATA 32'h0000_0004
`define NVM_ADDR_ADDRESS 32'h0000_0008
`define NVM_ADDR_BITSET 32'h0000_000c
`define NVM_ADDR_STATUS 32'h0000_0010

`define NVM_BIT_READ 0
`define NVM_BIT_WRITE 1
`define NVM_BIT_WEN 2
`define NVM_BIT_ERR 3
`define NVM_BIT_ERASE 4

`define NVM_ROW_LSB 3
`define NVM_ERASED_BYTE 8'hff
`define NVM_ERASE_NS 2000
`define NVM_WRITE_NS 1000
`define NVM_CLK_MHZ 50
`define NVM_ERASE_CYCLES ((`NVM_ERASE_NS * `NVM_CLK_MHZ + 999) / 1000)
`define NVM_WRITE_CYCLES ((`NVM_WRITE_NS * `NVM_CLK_MHZ + 999) / 1000)

`endif

// ==== design/nvm_ctrl.sv ====
/*
  flash data memory controller with an axi4-lite register slave.
  control offset: plain write (erase select may be set; read, enable and
  trigger bits cannot). bitset offset: single-bit-set write of one bit.
  assumes the core samples stall and holds instruction flow while it is high.
*/
`timescale 1ns/100ps
`include "nvm_cfg.svh"
module nvm_ctrl
  import nvm_pkg::*;
#(
  parameter int ERASE_CYCLES = `NVM_ERASE_CYCLES,
  parameter int WRITE_CYCLES = `NVM_WRITE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic stall
);
  // ****************************************
  // state
  // ****************************************
  nvm_state_e state, next_state;
  logic [15:0] cnt, next_cnt;
  logic [5:0] nvm_address_reg, next_address;
  logic [7:0] nvm_data_reg, next_data;
  logic erase_sel, next_erase_sel;
  logic write_enable_bit, next_wen;
  logic wen_age, next_wen_age;
  logic erase_age, next_erase_age;
  logic trig, next_trig;
  logic err, next_err;
  logic [7:0] array_rdata;
  logic arr_prog, arr_erase;
  logic aw_got, next_aw_got, w_got, next_w_got;
  logic [31:0] aw_addr, next_aw_addr, w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic next_stall;

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a == `NVM_ADDR_CONTROL) || (a == `NVM_ADDR_DATA) ||
             (a == `NVM_ADDR_ADDRESS) || (a == `NVM_ADDR_BITSET) ||
             (a == `NVM_ADDR_STATUS);
  endfunction

  // the array sits only behind the registers
  nvm_array #(.ROWS(8), .ROW_BYTES(8)) u_array (
    .aclk(aclk),
    .aresetn(aresetn),
    .addr(nvm_address_reg),
    .wdata(nvm_data_reg),
    .prog(arr_prog),
    .erase(arr_erase),
    .rdata(array_rdata)
  );

  // ****************************************
  // control
  // ****************************************
  logic do_write;
  logic [31:0] bit_pos;
  always_comb begin
    do_write = aw_got && w_got && !s_axi_bvalid && (state == st_idle);
    bit_pos = w_data;
    next_state = state;
    next_cnt = cnt;
    next_address = nvm_address_reg;
    next_data = nvm_data_reg;
    next_erase_sel = erase_sel;
    next_wen = write_enable_bit;
    next_trig = trig;
    next_err = err;
    // an instruction is one accepted write; ages last until the next one
    next_wen_age = wen_age && !do_write;
    next_erase_age = erase_age && !do_write;
    arr_prog = 1'b0;
    arr_erase = 1'b0;
    // unlock bits lapse at the next instruction unless it sets the next bit
    if (do_write && erase_age && !write_enable_bit) next_erase_sel = 1'b0;
    if (do_write && wen_age && !trig) next_wen = 1'b0;
    if (do_write && w_strb[0]) begin
      case (aw_addr)
        `NVM_ADDR_CONTROL: begin
          // plain write: erase select may be set or cleared; error and write enable may only be cleared
          next_erase_sel = w_data[`NVM_BIT_ERASE];
          next_erase_age = w_data[`NVM_BIT_ERASE];
          next_err = w_data[`NVM_BIT_ERR] & err;
          if (!w_data[`NVM_BIT_WEN]) next_wen = 1'b0;
        end
        `NVM_ADDR_DATA: next_data = w_data[7:0];
        `NVM_ADDR_ADDRESS: next_address = w_data[5:0];
        `NVM_ADDR_BITSET: begin
          case (bit_pos[2:0])
            3'h0: next_data = array_rdata;
            3'h2: begin
              if (erase_age || !erase_sel) begin
                next_wen = 1'b1;
                next_wen_age = 1'b1;
                if (erase_age) next_erase_sel = 1'b1;
              end
            end
            3'h1: begin
              if (wen_age) begin
                next_trig = 1'b1;
                next_wen = 1'b1;
                next_state = erase_sel ? st_erase : st_write;
                next_cnt = 16'(erase_sel ? ERASE_CYCLES : WRITE_CYCLES);
              end else begin
                next_err = 1'b1;
              end
            end
            3'h4: begin
              next_erase_sel = 1'b1;
              next_erase_age = 1'b1;
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end
    case (state)
      st_idle: ;
      st_erase, st_write: begin
        next_erase_age = 1'b0;
        next_wen_age = 1'b0;
        if (cnt <= 16'h0001) begin
          if (state == st_erase) arr_erase = 1'b1;
          else arr_prog = 1'b1;
          next_state = st_idle;
          next_trig = 1'b0;
          next_wen = 1'b0;
          next_erase_sel = 1'b0;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      default: next_state = st_idle;
    endcase
    // stall through erase/write; reads complete in the access itself
    next_stall = (next_state != st_idle);
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_arready = 1'b0;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(aw_addr) ? 2'h0 : 2'h2;
    end
    if (s_axi_bvalid && s_axi_bready) next_bvalid = 1'b0;
    next_awready = !next_aw_got && !next_bvalid;
    next_wready = !next_w_got && !next_bvalid;
    if (s_axi_rvalid && s_axi_rready) next_rvalid = 1'b0;
    if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
      next_arready = 1'b1;
      next_rvalid = 1'b1;
      next_rresp = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      case (s_axi_araddr)
        `NVM_ADDR_CONTROL, `NVM_ADDR_STATUS: next_rdata = {27'h0, erase_sel, err,
          write_enable_bit, trig, 1'b0};
        `NVM_ADDR_DATA: next_rdata = {24'h0, nvm_data_reg};
        `NVM_ADDR_ADDRESS: next_rdata = {26'h0, nvm_address_reg};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_idle;
      cnt <= 16'h0;
      nvm_address_reg <= 6'h0;
      nvm_data_reg <= 8'h0;
      erase_sel <= 1'b0;
      write_enable_bit <= 1'b0;
      wen_age <= 1'b0;
      erase_age <= 1'b0;
      trig <= 1'b0;
      err <= 1'b0;
      stall <= 1'b0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 32'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      nvm_address_reg <= next_address;
      nvm_data_reg <= next_data;
      erase_sel <= next_erase_sel;
      write_enable_bit <= next_wen;
      wen_age <= next_wen_age;
      erase_age <= next_erase_age;
      trig <= next_trig;
      err <= next_err;
      stall <= next_stall;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_enable_lapse: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && wen_age && aw_addr != `NVM_ADDR_BITSET |=> !write_enable_bit)
    else $error("write enable did not lapse");
  a_select_lapse: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && erase_age && aw_addr != `NVM_ADDR_CONTROL && aw_addr != `NVM_ADDR_BITSET
    |=> !erase_sel)
    else $error("erase select did not lapse");
  a_error_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && w_strb[0] && aw_addr == `NVM_ADDR_BITSET && w_data[2:0] == 3'h1 && !wen_age
    |=> err && !trig)
    else $error("locked trigger not refused");
  a_no_early_start: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(stall) |-> $past(do_write) && $past(wen_age))
    else $error("cycle started without unlock");
  a_trigger_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(trig) |-> $past(wen_age))
    else $error("trigger without unlock");
  a_stall_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    (state != st_idle) |-> stall)
    else $error("no stall during cycle");
  a_end_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (state != st_idle) ##1 (state == st_idle) |-> !trig && !write_enable_bit && !erase_sel)
    else $error("bits not cleared at end");
  a_read_data: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && w_strb[0] && aw_addr == `NVM_ADDR_BITSET && w_data[2:0] == 3'h0
    |=> nvm_data_reg == $past(array_rdata))
    else $error("read data not loaded");
  a_data_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    !do_write |=> $stable(nvm_data_reg))
    else $error("data register changed");
  a_plain_no_trig: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_addr == `NVM_ADDR_CONTROL && !trig |=> !trig)
    else $error("plain write set trigger");
  c_erase: cover property (@(posedge aclk) state == st_erase ##1 state == st_idle);
  c_write: cover property (@(posedge aclk) state == st_write ##1 state == st_idle);
  c_lapse: cover property (@(posedge aclk) write_enable_bit ##1 !write_enable_bit);
  c_error: cover property (@(posedge aclk) $rose(err));
endmodule

// ==== design/nvm_pkg.sv ====
/*
  types for the flash data memory control block.
  assumes nothing beyond a systemverilog compiler.
*/
package nvm_pkg;
  typedef enum logic [1:0] {st_idle, st_erase, st_write} nvm_state_e;
endpackage

// ==== sim/core_model.sv ====
/*
  behavioural processor core: issues one register write or read at a time
  on the axi4-lite slave and holds instruction flow while stall is high.
  assumes the bench calls write and read one after another.
*/
`timescale 1ns/100ps
module core_model (
  input wire logic aclk,
  input wire logic stall,
  output logic [31:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [31:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // ****************
  // instruction flow
  // ****************
  task automatic hold_while_stalled();
    while (stall !== 1'b0) @(posedge aclk);
  endtask

  task automatic write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    hold_while_stalled();
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    hold_while_stalled();
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
endmodule

// ==== sim/tb_top.sv ====
/*
  self-checking bench for the flash data memory controller.
  assumes the core model drives the register bus and short cycle counts.
*/
`timescale 1ns/100ps
`include "nvm_cfg.svh"
module tb_top;
  localparam int ec = 6;
  localparam int wc = 4;
  localparam logic [31:0] ctl_a = `NVM_ADDR_CONTROL;
  localparam logic [31:0] dat_a = `NVM_ADDR_DATA;
  localparam logic [31:0] adr_a = `NVM_ADDR_ADDRESS;
  localparam logic [31:0] bset_a = `NVM_ADDR_BITSET;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic stall;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int bad_count = 0;
  int compares = 0;
  int stall_cycles = 0;

  always #10 aclk = ~aclk;
  always @(posedge aclk) if (stall === 1'b1) stall_cycles <= stall_cycles + 1;

  nvm_ctrl #(.ERASE_CYCLES(ec), .WRITE_CYCLES(wc)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .stall(stall));

  core_model u_core (.aclk(aclk), .stall(stall), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ****************
  // shared tasks
  // ****************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_core.write(a, d, r);
    check({30'h0, r}, 32'h0);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    u_core.read(a, d, r);
    check(d & m, exp);
  endtask

  task automatic read_byte(input logic [5:0] a, input logic [7:0] exp);
    wr(adr_a, {26'h0, a});
    wr(bset_a, `NVM_BIT_READ);
    rd(dat_a, 32'hff, {24'h0, exp});
  endtask

  task automatic prog_byte(input logic [5:0] a, input logic [7:0] v);
    wr(adr_a, {26'h0, a});
    wr(dat_a, {24'h0, v});
    wr(bset_a, `NVM_BIT_WEN);
    wr(bset_a, `NVM_BIT_WRITE);
  endtask

  task automatic stall_span(input int s0, input int n);
    check(32'(stall_cycles - s0 >= n && stall_cycles - s0 <= n + 2), 32'h1);
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_idle();
    rd(ctl_a, 32'h1f, 32'h0);
    for (int i = 0; i < 64; i++) read_byte(6'(i), `NVM_ERASED_BYTE);
  endtask

  task automatic t_program();
    int s0;
    s0 = stall_cycles;
    prog_byte(6'h0d, 8'h5a);
    rd(ctl_a, 32'h17, 32'h0);
    stall_span(s0, wc);
    read_byte(6'h0d, 8'h5a);
    read_byte(6'h0c, 8'hff);
    read_byte(6'h0e, 8'hff);
  endtask

  task automatic t_erase();
    int s0;
    prog_byte(6'h18, 8'h33);
    prog_byte(6'h1f, 8'h44);
    prog_byte(6'h20, 8'h66);
    prog_byte(6'h17, 8'h77);
    read_byte(6'h1f, 8'h44);
    s0 = stall_cycles;
    wr(adr_a, 32'h1c);
    wr(ctl_a, 32'h10);
    wr(bset_a, `NVM_BIT_WEN);
    wr(bset_a, `NVM_BIT_WRITE);
    rd(ctl_a, 32'h17, 32'h0);
    stall_span(s0, ec);
    read_byte(6'h18, 8'hff);
    read_byte(6'h1f, 8'hff);
    read_byte(6'h20, 8'h66);
    read_byte(6'h17, 8'h77);
    read_byte(6'h0d, 8'h5a);
    prog_byte(6'h1f, 8'h44);
    read_byte(6'h1f, 8'h44);
  endtask

  task automatic t_lapse();
    int s0;
    wr(bset_a, `NVM_BIT_ERASE);
    wr(dat_a, 32'h0);
    rd(ctl_a, 32'h10, 32'h0);
    wr(bset_a, `NVM_BIT_WEN);
    wr(dat_a, 32'h0);
    rd(ctl_a, 32'h04, 32'h0);
    s0 = stall_cycles;
    wr(adr_a, 32'h0c);
    wr(dat_a, 32'h99);
    wr(bset_a, `NVM_BIT_WRITE);
    rd(ctl_a, 32'h0a, 32'h08);
    wr(ctl_a, 32'h07);
    rd(ctl_a, 32'h07, 32'h0);
    check(32'(stall_cycles - s0), 32'h0);
    read_byte(6'h0c, 8'hff);
  endtask

  task automatic t_hold();
    logic [31:0] d;
    logic [1:0] r;
    read_byte(6'h0d, 8'h5a);
    wr(adr_a, 32'h21);
    rd(dat_a, 32'hff, 32'h5a);
    wr(dat_a, 32'h3c);
    wr(ctl_a, 32'h01);
    rd(dat_a, 32'hff, 32'h3c);
    u_core.read(32'h40, d, r);
    check({30'h0, r}, 32'h2);
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge aclk);
    bad_count++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({31'h0, stall}, 32'h0);
    t_idle();
    t_program();
    t_erase();
    t_lapse();
    t_hold();
    final_report();
  end
endmodule
